//--- pscfg_host_model.sv
// Purpose: host side of the passive serial load, drives request, load clock and image bits
// Assumes: the bench calls the tasks; the status line has a board pull-up
// Notes: the load clock runs only inside a frame, with a 48 ns period
`timescale 1ns/100ps
module pscfg_host_model #(
  parameter int BITS = 16,
  parameter int REL_WAIT = 75300
) (
  // system clock and wire level of the status line
  input wire logic clk,
  input wire logic status_line,
  // host outputs
  output logic reconfig_request_n,
  output logic config_clock,
  output logic config_data
);
  int since_rise = 0;

  // clk cycles since the request was last seen low
  always @(posedge clk) begin
    since_rise <= reconfig_request_n ? since_rise + 1 : 0;
  end

  // idle levels at time zero, load clock parked low
  initial begin
    reconfig_request_n = 1'b1;
    config_clock = 1'b0;
    config_data = 1'b0;
  end

  // request level; the caller keeps it low for 100 cycles or more
  task automatic set_request(input logic v);
    @(posedge clk);
    reconfig_request_n <= v;
  endtask : set_request

  // one image, clocked only once status is high and 2 us have passed
  task automatic send_frame(input logic [BITS-1:0] img);
    int n;
    n = 0;
    // also wait the longest release time after the request rose
    while ((status_line !== 1'b1 || since_rise < REL_WAIT) && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (100) @(posedge clk);
    #7; // load clock phase is unrelated to clk
    for (int i = 0; i < BITS; i++) begin
      config_data = img[i];
      #24 config_clock = 1'b1; // 24 ns phases stay above 45 percent of the fastest period
      #24 config_clock = 1'b0;
    end
    config_data = ~config_data; // hold time is over, so the line stops showing the last bit
  endtask : send_frame
endmodule : pscfg_host_model

//--- pscfg_link.sv
// Purpose: bit counter and parity on the host's load clock
// Assumes: the load clock runs only while the host shifts the image in
// Notes: cleared asynchronously from the system domain between frames, as this clock is stopped then
`timescale 1ns/100ps
module pscfg_link
  import pscfg_pkg::*;
#(
  parameter int CONFIG_BITS = CONFIG_BITS_DEFAULT
) (
  // link clock and serial data
  input wire logic config_clock,
  input wire logic config_data,
  // from the system domain: high while no frame may run
  input wire logic frame_clear,
  // to the system domain
  output logic done_level,
  output logic parity
);

  typedef struct packed {
    logic [BITCNT_W-1:0] count;
    logic done;
    logic par;
  } pscfg_link_type;

  pscfg_link_type r_q;
  pscfg_link_type r_d;

  if (CONFIG_BITS < 1 || CONFIG_BITS >= 2 ** BITCNT_W) begin : g_bad_bits
    $error("pscfg_link: CONFIG_BITS out of range");
  end

  // count bits until the image is complete; later edges are ignored
  always_comb begin
    r_d = r_q;
    if (!r_q.done) begin
      r_d.count = r_q.count + BITCNT_W'(1);
      r_d.par = r_q.par ^ config_data;
      if (r_q.count == BITCNT_W'(CONFIG_BITS - 1)) begin
        r_d.done = 1'b1;
      end
    end
  end

  // a synchronous clear could not act on a stopped clock; the clear is released
  // microseconds before the host's first edge, so its release is never near an edge
  always_ff @(posedge config_clock or posedge frame_clear) begin
    if (frame_clear) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // done and parity stand still after the last bit, so two flops suffice
  assign done_level = r_q.done;
  assign parity = r_q.par;

endmodule : pscfg_link

//--- pscfg_pkg.sv
// Purpose: shared constants and state codes of the passive serial load handshake
// Assumes: system clock of 50 MHz
// Notes: each time is kept in its own unit, the cycle count is derived from it
package pscfg_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 20;

  // response of both open lines to a falling request
  localparam int RESP_MAX_NS = 600;
  localparam int RESP_MAX_CYC = RESP_MAX_NS / CLK_PERIOD_NS;

  // status low pulse, least width and longest release after the request rises
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_US = 1506;
  localparam int STATUS_MAX_CYC = STATUS_MAX_US * 1000 / CLK_PERIOD_NS;

  // initialisation on the internal oscillator: window and chosen point inside it
  localparam int OSC_MIN_US = 175;
  localparam int OSC_MIN_CYC = (OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_MAX_US = 437;
  localparam int OSC_MAX_CYC = OSC_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int INIT_OSC_US = 200;
  localparam int INIT_OSC_CYC = (INIT_OSC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // user clock option: gap of four fastest load clock periods, then fixed cycle count
  localparam int LOAD_CLK_MIN_PERIOD_NS = 8;
  localparam int USER_GAP_PERIODS = 4;
  localparam int USER_GAP_NS = USER_GAP_PERIODS * LOAD_CLK_MIN_PERIOD_NS;
  localparam int USER_GAP_CYC = (USER_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_USER_CYCLES = 8576;

  // image length in bits, counter widths and pin synchroniser latency
  localparam int CONFIG_BITS_DEFAULT = 4096;
  localparam int TIMER_W = 20;
  localparam int UCNT_W = 14;
  localparam int BITCNT_W = 24;
  localparam int SYNC_LATENCY = 3;

  // handshake sequence
  typedef enum logic [3:0] {
    ST_PULSE,
    ST_RELEASE,
    ST_LOAD,
    ST_DONE_WAIT,
    ST_OSC_INIT,
    ST_USER_GAP,
    ST_USER_COUNT,
    ST_USER_MODE
  } pscfg_state_type;

endpackage : pscfg_pkg

//--- pscfg_sync.sv
// Purpose: two flip-flop level synchroniser for a group of bits
// Assumes: each bit is a level that stays put for several destination clocks
// Notes: the first stage is read only by the second stage
`timescale 1ns/100ps
module pscfg_sync #(
  parameter int W = 1
) (
  // destination clock
  input wire logic clk,
  // levels from another domain
  input wire logic [W-1:0] d,
  // synchronised levels
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pscfg_sync_type;

  pscfg_sync_type r_q;
  pscfg_sync_type r_d;

  // no reset: a reset would only hide one sample of the source
  always_comb begin
    r_d = r_q;
    r_d.meta = d;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge clk) begin
    r_q <= r_d;
  end

  assign q = r_q.stable;

endmodule : pscfg_sync

//--- pscfg_top.sv
// Purpose: device side of the passive serial load handshake
// Assumes: 50 MHz system clock, load clock from the host as its own domain
// Notes: open lines drive low only; the board pull-up makes them high
// Function
// RQ1 - The host holds the reconfiguration request low for at least 2 us to start a new cycle.
// RQ2 - The device pulls the status line low within 600 ns after the request falls.
// RQ3 - The device drives the load-complete line low within 600 ns after the request falls.
// RQ4 - The status low pulse lasts at least 268 us and at most 1506 us when nobody stretches it.
// RQ5 - The device releases the status line within 1506 us after the request rises.
// RQ6 - Loading waits until both the request and the status line are released.
// RQ7 - A host not watching status waits 1506 us after raising the request before its first clock edge.
// RQ8 - A host watching status waits 2 us after status rises before its first clock edge.
// RQ9 - With the internal oscillator, user mode comes 175 to 437 us after load-complete rises.
// RQ10 - The user clock counts only from four fastest load clock periods after load-complete rises.
// RQ11 - With the user clock option, user mode comes after 8576 user clock cycles.
// RQ12 - The host keeps the load clock within the highest rate and its high and low phases.
`timescale 1ns/100ps
module pscfg_top
  import pscfg_pkg::*;
#(
  parameter int STATUS_MIN = STATUS_MIN_CYC,
  parameter int STATUS_MAX = STATUS_MAX_CYC,
  parameter int INIT_OSC = INIT_OSC_CYC,
  parameter int OSC_MIN = OSC_MIN_CYC,
  parameter int OSC_MAX = OSC_MAX_CYC,
  parameter int INIT_USER = INIT_USER_CYCLES,
  parameter int CONFIG_BITS = CONFIG_BITS_DEFAULT
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // host request and serial data on the load clock
  input wire logic reconfig_request_n,
  input wire logic config_clock,
  input wire logic config_data,
  // open-drain status line
  input wire logic status_n_in,
  output logic status_n_out,
  output logic status_n_oe,
  // open-drain load-complete line
  input wire logic load_complete_in,
  output logic load_complete_out,
  output logic load_complete_oe,
  // initialisation clock choice
  input wire logic user_clock,
  input wire logic user_clock_init_sel,
  // results
  output logic user_mode,
  output logic config_parity
);

  typedef struct packed {
    pscfg_state_type state;
    logic [TIMER_W-1:0] timer;
    logic [UCNT_W-1:0] ucnt;
    logic uclk_prev;
    logic done_prev;
    logic link_clr;
    logic use_uclk;
    logic status_oe;
    logic load_oe;
    logic umode;
    logic parity;
  } pscfg_top_type;

  pscfg_top_type r_q;
  pscfg_top_type r_d;
  logic req_s;
  logic stat_s;
  logic load_s;
  logic uclk_s;
  logic sel_s;
  logic done_s;
  logic par_s;
  logic link_done;
  logic link_par;
  logic done_evt;
  logic uclk_rise;

  // refuse parameters the counters or timing cannot serve
  if (STATUS_MAX >= 2 ** TIMER_W || INIT_OSC >= 2 ** TIMER_W || STATUS_MIN > STATUS_MAX) begin : g_bad_timer
    $error("pscfg_top: timer parameter out of range");
  end
  if (INIT_USER < 1 || INIT_USER >= 2 ** UCNT_W) begin : g_bad_user
    $error("pscfg_top: INIT_USER out of range");
  end
  if (SYNC_LATENCY > RESP_MAX_CYC) begin : g_bad_resp
    $error("pscfg_top: pin synchroniser too slow for the response time");
  end

  // all pins but rst come through two flops before the sequencer looks at them
  pscfg_sync #(.W(5)) u_pin_sync (
    .clk(clk),
    .d({reconfig_request_n, status_n_in, load_complete_in, user_clock, user_clock_init_sel}),
    .q({req_s, stat_s, load_s, uclk_s, sel_s})
  );

  // bit counting on the host clock; the link is held clear from a flop of this
  // domain whenever no load runs, since the host clock may be stopped there.
  // the clear drops on entry to the load state, nearly 2 us before the first
  // host edge, so the first bit of the image is always counted
  pscfg_link #(.CONFIG_BITS(CONFIG_BITS)) u_link (
    .config_clock(config_clock),
    .config_data(config_data),
    .frame_clear(r_q.link_clr),
    .done_level(link_done),
    .parity(link_par)
  );

  // done and parity are levels that stay put once the image is in
  pscfg_sync #(.W(2)) u_link_sync (
    .clk(clk),
    .d({link_done, link_par}),
    .q({done_s, par_s})
  );

  // events from the synchronised levels
  assign done_evt = done_s && !r_q.done_prev; // done is cleared between frames, so its rise marks the end
  assign uclk_rise = uclk_s && !r_q.uclk_prev;

  // sequencer: the request pulled low restarts the pulse from any other state
  always_comb begin
    r_d = r_q;
    r_d.uclk_prev = uclk_s;
    r_d.done_prev = done_s;
    r_d.timer = r_q.timer + TIMER_W'(1);
    if (!req_s && r_q.state != ST_PULSE) begin
      r_d.state = ST_PULSE;
      r_d.timer = '0;
      r_d.status_oe = 1'b1; // [RQ2]
      r_d.load_oe = 1'b1; // [RQ3]
      r_d.umode = 1'b0;
    end else begin
      case (r_q.state)
        ST_PULSE: begin
          // low pulse keeps its least width even for a short request
          if (req_s && r_q.timer >= TIMER_W'(STATUS_MIN - 1)) begin // [RQ4] [RQ5]
            r_d.state = ST_RELEASE;
            r_d.status_oe = 1'b0;
          end
        end
        ST_RELEASE: begin
          // someone else may stretch status low; wait for both lines
          if (req_s && stat_s) begin // [RQ6]
            r_d.state = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (done_evt) begin
            r_d.state = ST_DONE_WAIT;
            r_d.load_oe = 1'b0;
            r_d.parity = par_s;
          end
        end
        ST_DONE_WAIT: begin
          // initialisation time is measured from the line really being high
          r_d.timer = '0;
          if (load_s) begin
            r_d.use_uclk = sel_s;
            r_d.state = sel_s ? ST_USER_GAP : ST_OSC_INIT;
          end
        end
        ST_OSC_INIT: begin
          if (r_q.timer >= TIMER_W'(INIT_OSC - 1)) begin // [RQ9]
            r_d.state = ST_USER_MODE;
            r_d.umode = 1'b1;
          end
        end
        ST_USER_GAP: begin
          // user clock edges inside the gap are ignored
          r_d.ucnt = '0;
          if (r_q.timer >= TIMER_W'(USER_GAP_CYC - 1)) begin // [RQ10]
            r_d.state = ST_USER_COUNT;
          end
        end
        ST_USER_COUNT: begin
          if (uclk_rise) begin
            r_d.ucnt = r_q.ucnt + UCNT_W'(1);
            if (r_q.ucnt == UCNT_W'(INIT_USER - 1)) begin // [RQ11]
              r_d.state = ST_USER_MODE;
              r_d.umode = 1'b1;
            end
          end
        end
        ST_USER_MODE: begin
          r_d.timer = r_q.timer;
        end
        default: begin
          r_d.state = ST_PULSE;
          r_d.timer = '0;
        end
      endcase
    end
    // the link is free to count only while the sequencer is loading
    r_d.link_clr = (r_d.state != ST_LOAD); // [RQ6]
  end

  // reset behaves like a fresh request: both lines low, pulse timer from zero
  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '{state: ST_PULSE, timer: '0, ucnt: '0, uclk_prev: 1'b0, done_prev: 1'b0,
               link_clr: 1'b1, use_uclk: 1'b0, status_oe: 1'b1, load_oe: 1'b1,
               umode: 1'b0, parity: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // open-drain lines only ever drive zero
  assign status_n_out = 1'b0;
  assign load_complete_out = 1'b0;
  assign status_n_oe = r_q.status_oe;
  assign load_complete_oe = r_q.load_oe;
  assign user_mode = r_q.umode;
  assign config_parity = r_q.parity;

  // helper counters watched only by the checks below
  logic [TIMER_W-1:0] ast_low_q;
  logic [TIMER_W-1:0] ast_rel_q;
  logic [TIMER_W-1:0] ast_init_q;
  logic [UCNT_W-1:0] ast_edges_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ast_low_q <= '0;
      ast_rel_q <= '0;
      ast_init_q <= '0;
      ast_edges_q <= '0;
    end else begin
      ast_low_q <= r_q.status_oe ? ast_low_q + TIMER_W'(1) : '0;
      ast_rel_q <= (r_q.status_oe && req_s) ? ast_rel_q + TIMER_W'(1) : '0;
      ast_init_q <= (r_q.state == ST_OSC_INIT) ? ast_init_q + TIMER_W'(1) : '0;
      if (r_q.state == ST_USER_GAP) begin
        ast_edges_q <= '0;
      end else if (r_q.state == ST_USER_COUNT && uclk_rise) begin
        ast_edges_q <= ast_edges_q + UCNT_W'(1);
      end
    end
  end

  sequence seq_req_low;
    !req_s;
  endsequence
  sequence seq_lines_free;
    req_s && stat_s;
  endsequence

  AST_STATUS_FALLS: assert property (@(posedge clk) disable iff (rst) // [RQ2]
    seq_req_low |-> ##[0:2] status_n_oe) else $error("status not pulled low after request");
  AST_LOAD_FALLS: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    seq_req_low |-> ##[0:2] (load_complete_oe && !user_mode)) else $error("load-complete not low after request");
  AST_PULSE_MIN: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    $fell(status_n_oe) |-> $past(ast_low_q) >= TIMER_W'(STATUS_MIN - 1)) else $error("status pulse too short");
  AST_RELEASE_MAX: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    ast_rel_q <= TIMER_W'(STATUS_MAX)) else $error("status held too long after request rose");
  AST_LOAD_WAITS: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    (r_q.state == ST_RELEASE && r_d.state == ST_LOAD) |-> seq_lines_free) else $error("load began with a line low");
  AST_OSC_WINDOW: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    ($rose(user_mode) && !r_q.use_uclk) |-> ($past(ast_init_q) + TIMER_W'(3) >= TIMER_W'(OSC_MIN)
      && $past(ast_init_q) <= TIMER_W'(OSC_MAX))) else $error("oscillator init outside window");
  AST_GAP_IGNORES: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    (r_q.state == ST_USER_GAP) |=> (r_q.ucnt == '0)) else $error("user clock counted inside gap");
  AST_USER_COUNT: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    ($rose(user_mode) && r_q.use_uclk) |-> ast_edges_q == UCNT_W'(INIT_USER)) else $error("user init count wrong");
  AST_MODE_HOLDS: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    (user_mode && req_s) |=> (user_mode && !status_n_oe && !load_complete_oe)) else $error("user mode left without request");

  // the link must be held clear whenever the sequencer is away from loading
  AST_LINK_CLEARED: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    (r_q.state != ST_LOAD) |-> r_q.link_clr) else $error("link not cleared outside load");

  // parity is a result level: once load-complete is released it stays put
  AST_PARITY_HOLDS: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    (!load_complete_oe && !$past(load_complete_oe)) |-> $stable(config_parity))
    else $error("parity changed after load");

  // user mode only ever follows a finished load with status released
  AST_MODE_AFTER_LOAD: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    $rose(user_mode) |-> (!load_complete_oe && !status_n_oe)) else $error("user mode before load end");

  // status is only released once the request has been seen high
  AST_RELEASE_NEEDS_REQ: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    $fell(status_n_oe) |-> $past(req_s)) else $error("status released while request low");

  // the user clock gap: it ends after its count and hands over to counting
  sequence seq_gap_done;
    r_q.state == ST_USER_GAP && r_q.timer >= TIMER_W'(USER_GAP_CYC - 1);
  endsequence

  AST_GAP_LEAVES: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    seq_gap_done |=> (r_q.state == ST_USER_COUNT || r_q.state == ST_PULSE))
    else $error("user clock gap not left");

  // counting never starts without passing through the gap first
  AST_GAP_FIRST: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    $rose(r_q.state == ST_USER_COUNT) |-> $past(r_q.state) == ST_USER_GAP)
    else $error("user clock counted without gap");

endmodule : pscfg_top

//--- pscfg_top_tb_top.sv
// Purpose: self-checking bench of the passive serial load handshake
// Assumes: shortened counts through parameters, user clock period of 6 clk
// Notes: load parity is noted in a queue and checked when load-complete is released
`timescale 1ns/100ps
module pscfg_top_tb_top import pscfg_pkg::*;;
  localparam int SMIN = 150;
  localparam int SMAX = 400;
  localparam int OMIN = 20;
  localparam int OMAX = 60;
  localparam int IUSER = 8;
  localparam int NBITS = 16;
  localparam int UPER = 6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reconfig_request_n, config_clock, config_data;
  logic status_n_out, status_n_oe, load_complete_out, load_complete_oe;
  logic user_clock = 1'b0;
  logic user_clock_init_sel = 1'b0;
  logic user_mode, config_parity;
  logic host_hold = 1'b0;
  logic status_line, lc_line, lc_q;
  logic [31:0] seed = 32'h0000_a3d8;
  logic exp_par[$];
  int uc_cnt = 0;
  int n_fail = 0;
  int check_count = 0;

  // open lines: pull-up unless someone pulls low; the host may stretch status
  assign status_line = ~status_n_oe & ~host_hold;
  assign lc_line = ~load_complete_oe;

  always #10 clk = ~clk;

  // user clock with phases of 3 clk, kept well below the sync limit
  always @(posedge clk) begin
    uc_cnt <= (uc_cnt == UPER / 2 - 1) ? 0 : uc_cnt + 1;
    if (uc_cnt == UPER / 2 - 1) begin
      user_clock <= ~user_clock;
    end
  end

  pscfg_top #(.STATUS_MIN(SMIN), .STATUS_MAX(SMAX), .INIT_OSC(30), .OSC_MIN(OMIN), .OSC_MAX(OMAX),
    .INIT_USER(IUSER), .CONFIG_BITS(NBITS)) u_dut (
    .clk(clk), .rst(rst), .reconfig_request_n(reconfig_request_n), .config_clock(config_clock),
    .config_data(config_data), .status_n_in(status_line), .status_n_out(status_n_out),
    .status_n_oe(status_n_oe), .load_complete_in(lc_line), .load_complete_out(load_complete_out),
    .load_complete_oe(load_complete_oe), .user_clock(user_clock),
    .user_clock_init_sel(user_clock_init_sel), .user_mode(user_mode), .config_parity(config_parity));

  pscfg_host_model #(.BITS(NBITS), .REL_WAIT(SMAX)) u_host (
    .clk(clk), .status_line(status_line), .reconfig_request_n(reconfig_request_n),
    .config_clock(config_clock), .config_data(config_data));

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // sample just after the edge so that the design's updates have landed
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic compare_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %b", $time, what, got);
    end
  endtask : compare_bit

  task automatic check_range(input int n, input int lo, input int hi, input string what);
    check_count++;
    if (n < lo || n > hi) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, n);
    end
  endtask : check_range

  // bounded wait for a level; a used-up bound ends the run
  task automatic wait_level(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v) begin
      tick();
      n++;
      if (n > lim) begin
        n_fail++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        report_and_stop();
      end
    end
  endtask : wait_level

  // load result: parity noted by the driver, taken when load-complete is released
  always @(posedge clk) begin
    lc_q <= load_complete_oe;
    if (lc_q === 1'b1 && load_complete_oe === 1'b0) begin
      if (exp_par.size() == 0) begin
        compare_bit(1'b1, 1'b0, "unexpected load end");
      end else begin
        compare_bit(config_parity, exp_par.pop_front(), "image parity");
      end
    end
  end

  // one full cycle: optional request pulse, optional status stretch, frame, init
  task automatic run_cycle(input logic sel, input int low_len, input int hold);
    int n;
    int m;
    logic [NBITS-1:0] img;
    @(posedge clk);
    user_clock_init_sel <= sel;
    m = 0;
    if (low_len > 0) begin
      u_host.set_request(1'b0);
      #1;
      wait_level(status_n_oe, 1'b1, RESP_MAX_CYC, n);
      wait_level(load_complete_oe, 1'b1, RESP_MAX_CYC, n);
      tick();
      compare_bit(user_mode, 1'b0, "user mode left on request");
      repeat (low_len) tick();
      compare_bit(status_n_oe, 1'b1, "status held while request low");
      host_hold <= (hold > 0);
      u_host.set_request(1'b1);
      #1;
    end
    wait_level(status_n_oe, 1'b0, SMAX, n);
    check_range(n, 0, SMAX, "status release after request high");
    check_range(low_len + n, SMIN - 3, SMIN + SMAX + low_len, "status pulse width");
    if (hold > 0) begin
      repeat (hold) tick();
      compare_bit(load_complete_oe, 1'b1, "no load while status stretched");
      host_hold <= 1'b0;
    end
    img = NBITS'(xorshift());
    exp_par.push_back(^img);
    u_host.send_frame(img);
    wait_level(load_complete_oe, 1'b0, 20, n);
    wait_level(user_mode, 1'b1, 2000, m);
    if (sel) begin
      check_range(m, (IUSER - 1) * UPER, (IUSER + 1) * UPER + 10, "user clock init");
    end else begin
      check_range(m, OMIN, OMAX, "oscillator init");
    end
    $display("test done: sel %0d, request low %0d, stretch %0d", sel, low_len, hold);
  endtask : run_cycle

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick();
    compare_bit(status_n_oe, 1'b1, "status low after reset");
    compare_bit(load_complete_oe, 1'b1, "load-complete low after reset");
    compare_bit(user_mode, 1'b0, "user mode after reset");
    run_cycle(1'b0, 0, 0);
    run_cycle(1'b0, 100, 0);
    run_cycle(1'b1, 500, 150);
    run_cycle(1'b0, 100, 0);
    report_and_stop();
  end
endmodule : pscfg_top_tb_top
